// ===== inc/crcchk_defs.vh
// Constants of the 16-bit checksum block: offsets, fields, resets.
// Assumes a 16-bit register port addressed by printed byte address.
`ifndef CRCCHK_DEFS_VH
`define CRCCHK_DEFS_VH

// Register byte addresses
`define CRCCHK_SAD_ADDR   16'hf0d0
`define CRCCHK_EAD_ADDR   16'hf0d2
`define CRCCHK_SSEG_ADDR  16'hf0d4
`define CRCCHK_ESEG_ADDR  16'hf0d6
`define CRCCHK_DATA_ADDR  16'hf0d8
`define CRCCHK_RES_ADDR   16'hf0da
`define CRCCHK_MOD_ADDR   16'hf0dc
`define CRCCHK_STAT_ADDR  16'hf0de
`define CRCCHK_MASK_ADDR  16'hf0e0

// Reset values
`define CRCCHK_SAD_RST    16'h0000
`define CRCCHK_EAD_RST    16'hfffc
`define CRCCHK_SSEG_RST   8'h00
`define CRCCHK_ESEG_RST   8'h0f
`define CRCCHK_DATA_RST   8'h00
`define CRCCHK_RES_RST    16'hffff
`define CRCCHK_MOD_RST    8'h00

// Mode register fields
`define CRCCHK_MOD_AEN    0
`define CRCCHK_MOD_DIR    1

// Status and mask field of the completion event
`define CRCCHK_IRQ_DONE   0

// Generator x^16+x^12+x^5+1, normal and bit-reversed form
`define CRCCHK_POLY_MSB   16'h1021
`define CRCCHK_POLY_LSB   16'h8408

`endif

// ===== hw/crcchk_step.v
// One byte folded into a 16-bit checksum, purely combinational.
// Assumes the caller registers the result; no state inside.
`timescale 1ns/100ps
`include "crcchk_defs.vh"

module crcchk_step (
    input  wire [15:0] crc_in,
    input  wire [7:0]  data_in,
    input  wire        msb_first,
    output wire [15:0] crc_out
);

    wire [15:0] chain [0:8];

    assign chain[0] = crc_in;

    // Eight single-bit shifts chained so one byte settles in a clock
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_bit
            wire        fb_lsb;
            wire        fb_msb;
            wire [15:0] nx_lsb;
            wire [15:0] nx_msb;
            assign fb_lsb = chain[i][0] ^ data_in[i];        // see [R2]
            assign fb_msb = chain[i][15] ^ data_in[7 - i];   // see [R2]
            assign nx_lsb = {1'b0, chain[i][15:1]} ^ (fb_lsb ? `CRCCHK_POLY_LSB : 16'h0000); // see [R1]
            assign nx_msb = {chain[i][14:0], 1'b0} ^ (fb_msb ? `CRCCHK_POLY_MSB : 16'h0000); // see [R1]
            assign chain[i + 1] = msb_first ? nx_msb : nx_lsb;
        end
    endgenerate

    assign crc_out = chain[8]; // see [R18]

endmodule // crcchk_step

// ===== hw/crcchk_irq.v
// Sticky event flags, mask and one level interrupt line.
// Assumes events are one-cycle pulses on the same clock.
`timescale 1ns/100ps

module crcchk_irq #(
    parameter WIDTH = 1
) (
    input  wire             clock,
    input  wire             reset,
    input  wire [WIDTH-1:0] event_set,
    input  wire [WIDTH-1:0] clear_ones,
    input  wire             mask_wr,
    input  wire [WIDTH-1:0] mask_wdata,
    output wire [WIDTH-1:0] status,
    output wire [WIDTH-1:0] mask,
    output wire             irq
);

    reg [WIDTH-1:0] status_q;
    reg [WIDTH-1:0] mask_q;

    // Per flag: a set in the clearing cycle wins so no event is lost
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
            always @(posedge clock) begin
                if (reset) begin
                    status_q[i] <= 1'b0;
                end else if (event_set[i]) begin
                    status_q[i] <= 1'b1;
                end else if (clear_ones[i]) begin
                    status_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Mask is plain storage, one bit per flag
    always @(posedge clock) begin
        if (reset) begin
            mask_q <= {WIDTH{1'b0}};
        end else if (mask_wr) begin
            mask_q <= mask_wdata;
        end
    end

    assign status = status_q;
    assign mask   = mask_q;
    assign irq    = |(status_q & mask_q);

endmodule // crcchk_irq

// ===== hw/crcchk_top.v
// Checksum generator with byte-wise manual mode and a program
// memory scan that runs while the processor is halted.
// Assumes halt and memory port are logic on the same clock and
// that memory answers with mem_valid only while mem_req is high.
//
// Summary of operation
// [R1] Checksum uses generator x^16+x^12+x^5+1 in both modes.
// [R2] Mode bit 1 picks bit order: 0 LSB first, 1 MSB first.
// [R3] A byte written to the input register updates the result one clock later.
// [R4] Software seeds the result register, reset 0xffff; hardware updates it in place.
// [R5] While auto enable is 1, writes to input byte and result are ignored.
// [R6] While auto enable is 1, writes to address and segment registers are ignored.
// [R7] Halt with auto enable set starts scanning memory from start to end.
// [R8] On completion auto enable clears and a completion request is raised.
// [R9] Automatic mode consumes memory as 32-bit words, four bytes each.
// [R10] Start address bits 1:0 ignore writes, read zero, act as zero.
// [R11] End address bits 1:0 ignore writes, read zero, act as ones; reset 0xfffc.
// [R12] Start address and segment advance as memory is read.
// [R13] Mode bit 0 enables automatic mode, reset 0; bits 7:2 reserved.
// [R14] Leaving halt aborts; the next halt resumes where it stopped.
// [R15] Scan ends when current segment and address equal the end pair.
// [R16] An enabled completion request releases the processor from halt.
// [R17] Word bytes enter lowest address first with the selected order.
// [R18] One byte step completes inside one clock, so writes never stall.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "crcchk_defs.vh"

module crcchk_top #(
    parameter SEG_W = 8
) (
    input  wire               clock,
    input  wire               reset,
    input  wire [15:0]        reg_addr,
    input  wire [15:0]        reg_wdata,
    input  wire               reg_wr,
    input  wire               reg_rd,
    output wire [15:0]        reg_rdata,
    input  wire               halt_active,
    input  wire               safety_interrupt_enable,
    output wire               mem_req,
    output wire [SEG_W+15:0]  mem_addr,
    input  wire [31:0]        mem_rdata,
    input  wire               mem_valid,
    output wire               auto_done,
    output wire               halt_release,
    output wire               irq
);

    // Scan states
    localparam ST_IDLE  = 2'd0;
    localparam ST_FETCH = 2'd1;
    localparam ST_GAP   = 2'd2;

    // Reset images, sliced down to the bits that are really stored
    localparam [15:0] SAD_RST = `CRCCHK_SAD_RST;
    localparam [15:0] EAD_RST = `CRCCHK_EAD_RST;
    localparam [7:0]  MOD_RST = `CRCCHK_MOD_RST;

    // Software-visible storage
    reg [15:2]      start_addr_q;
    reg [15:2]      end_addr_q;
    reg [SEG_W-1:0] start_seg_q;
    reg [SEG_W-1:0] end_seg_q;
    reg [7:0]       input_byte_q;
    reg [15:0]      result_q;
    reg             auto_check_enable_q;
    reg             shift_order_select_q;

    // Scan control and outputs
    reg [1:0]       state_q;
    reg [1:0]       state_d;
    reg [15:0]      rdata_q;
    reg             done_q;
    reg             release_q;

    // Decoded accesses
    wire wr_sad;
    wire wr_ead;
    wire wr_sseg;
    wire wr_eseg;
    wire wr_data;
    wire wr_res;
    wire wr_mod;
    wire wr_stat;
    wire wr_mask;
    wire locked;

    // Checksum datapath
    wire [15:0] step_in0;
    wire [7:0]  byte_in0;
    wire [15:0] stage1;
    wire [15:0] stage2;
    wire [15:0] stage3;
    wire [15:0] stage4;

    // Scan events and position
    wire               word_taken;
    wire               at_end;
    wire               finish;
    wire [SEG_W+13:0]  pos_next;
    wire [0:0]         irq_status;
    wire [0:0]         irq_mask;

    // Writes that the running scan must not disturb
    assign locked  = auto_check_enable_q;
    assign wr_sad  = reg_wr && (reg_addr == `CRCCHK_SAD_ADDR)  && !locked; // see [R6]
    assign wr_ead  = reg_wr && (reg_addr == `CRCCHK_EAD_ADDR)  && !locked; // see [R6]
    assign wr_sseg = reg_wr && (reg_addr == `CRCCHK_SSEG_ADDR) && !locked; // see [R6]
    assign wr_eseg = reg_wr && (reg_addr == `CRCCHK_ESEG_ADDR) && !locked; // see [R6]
    assign wr_data = reg_wr && (reg_addr == `CRCCHK_DATA_ADDR) && !locked; // see [R5]
    assign wr_res  = reg_wr && (reg_addr == `CRCCHK_RES_ADDR)  && !locked; // see [R5]

    // Mode, status and mask stay writable at all times
    assign wr_mod  = reg_wr && (reg_addr == `CRCCHK_MOD_ADDR);
    assign wr_stat = reg_wr && (reg_addr == `CRCCHK_STAT_ADDR);
    assign wr_mask = reg_wr && (reg_addr == `CRCCHK_MASK_ADDR);

    // A word is consumed only while a fetch is outstanding
    assign word_taken = (state_q == ST_FETCH) && mem_valid && halt_active && auto_check_enable_q;

    // End compare on word position; end bits 1:0 count as ones
    assign at_end = (start_seg_q == end_seg_q) && (start_addr_q == end_addr_q); // see [R15] [R11]
    assign finish = word_taken && at_end;

    // Next word position, carry runs from address into segment
    assign pos_next = {start_seg_q, start_addr_q} + {{(SEG_W+13){1'b0}}, 1'b1}; // see [R12]

    // Stage 0 is shared: the manual byte or the lowest byte of a word
    assign step_in0 = result_q;
    // Selected by the taken word, not the state, so a manual byte right
    // after an abort never folds in stale memory data
    assign byte_in0 = word_taken ? mem_rdata[7:0] : reg_wdata[7:0];

    // Four chained byte steps so a whole word folds in one clock
    crcchk_step u_step0 (
        .crc_in    (step_in0),
        .data_in   (byte_in0),
        .msb_first (shift_order_select_q),
        .crc_out   (stage1)
    );

    crcchk_step u_step1 (
        .crc_in    (stage1),
        .data_in   (mem_rdata[15:8]),
        .msb_first (shift_order_select_q),
        .crc_out   (stage2)
    );

    crcchk_step u_step2 (
        .crc_in    (stage2),
        .data_in   (mem_rdata[23:16]),
        .msb_first (shift_order_select_q),
        .crc_out   (stage3)
    );

    crcchk_step u_step3 (
        .crc_in    (stage3),
        .data_in   (mem_rdata[31:24]),
        .msb_first (shift_order_select_q),
        .crc_out   (stage4)
    );

    // Scan sequencer; a gap cycle separates fetches so memory sees
    // each new address as a fresh request
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (halt_active && auto_check_enable_q) begin
                    state_d = ST_FETCH; // see [R7]
                end
            end
            ST_FETCH: begin
                if (!halt_active || !auto_check_enable_q) begin
                    state_d = ST_IDLE; // see [R14]
                end else if (word_taken) begin
                    state_d = at_end ? ST_IDLE : ST_GAP;
                end
            end
            ST_GAP: begin
                if (halt_active) begin
                    state_d = ST_FETCH;
                end else begin
                    state_d = ST_IDLE; // see [R14]
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clock) begin
        if (reset) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Start position: software loads it, the scan advances it. Abort
    // leaves it on the word not yet consumed, so a resume refetches it
    always @(posedge clock) begin
        if (reset) begin
            start_addr_q <= SAD_RST[15:2];
            start_seg_q  <= `CRCCHK_SSEG_RST;
        end else begin
            if (word_taken && !at_end) begin
                {start_seg_q, start_addr_q} <= pos_next; // see [R12] [R14]
            end else begin
                if (wr_sad) begin
                    start_addr_q <= reg_wdata[15:2]; // see [R10]
                end
                if (wr_sseg) begin
                    start_seg_q <= reg_wdata[SEG_W-1:0];
                end
            end
        end
    end

    // End position is software storage only
    always @(posedge clock) begin
        if (reset) begin
            end_addr_q <= EAD_RST[15:2]; // see [R11]
            end_seg_q  <= `CRCCHK_ESEG_RST;
        end else begin
            if (wr_ead) begin
                end_addr_q <= reg_wdata[15:2]; // see [R11]
            end
            if (wr_eseg) begin
                end_seg_q <= reg_wdata[SEG_W-1:0];
            end
        end
    end

    // Input byte keeps the last accepted manual byte for readback
    always @(posedge clock) begin
        if (reset) begin
            input_byte_q <= `CRCCHK_DATA_RST;
        end else if (wr_data) begin
            input_byte_q <= reg_wdata[7:0];
        end
    end

    // Result: seed write, manual byte fold or whole-word fold; the
    // lock keeps the manual paths from racing a scan
    always @(posedge clock) begin
        if (reset) begin
            result_q <= `CRCCHK_RES_RST; // see [R4]
        end else if (word_taken) begin
            result_q <= stage4; // see [R9] [R17]
        end else if (wr_data) begin
            result_q <= stage1; // see [R3] [R18]
        end else if (wr_res) begin
            result_q <= reg_wdata; // see [R4]
        end
    end

    // Mode bits; completion clears the enable even against a write,
    // since the processor is halted whenever a scan can finish
    always @(posedge clock) begin
        if (reset) begin
            auto_check_enable_q  <= MOD_RST[`CRCCHK_MOD_AEN]; // see [R13]
            shift_order_select_q <= MOD_RST[`CRCCHK_MOD_DIR]; // see [R2]
        end else begin
            if (wr_mod) begin
                auto_check_enable_q  <= reg_wdata[`CRCCHK_MOD_AEN]; // see [R13]
                shift_order_select_q <= reg_wdata[`CRCCHK_MOD_DIR]; // see [R2]
            end
            if (finish) begin
                auto_check_enable_q <= 1'b0; // see [R8]
            end
        end
    end

    // Completion pulse and the halt release it may cause
    always @(posedge clock) begin
        if (reset) begin
            done_q    <= 1'b0;
            release_q <= 1'b0;
        end else begin
            done_q    <= finish; // see [R8]
            release_q <= finish && safety_interrupt_enable; // see [R16]
        end
    end

    // Completion flag for software with its own mask
    crcchk_irq #(
        .WIDTH (1)
    ) u_irq (
        .clock      (clock),
        .reset      (reset),
        .event_set  (finish),
        .clear_ones (reg_wdata[`CRCCHK_IRQ_DONE] & wr_stat),
        .mask_wr    (wr_mask),
        .mask_wdata (reg_wdata[`CRCCHK_IRQ_DONE]),
        .status     (irq_status),
        .mask       (irq_mask),
        .irq        (irq)
    );

    // Read data registered, valid only in the cycle after the strobe;
    // unmapped addresses and reserved bits read zero
    always @(posedge clock) begin
        if (reset) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `CRCCHK_SAD_ADDR: begin
                    rdata_q <= {start_addr_q, 2'b00}; // see [R10]
                end
                `CRCCHK_EAD_ADDR: begin
                    rdata_q <= {end_addr_q, 2'b00}; // see [R11]
                end
                `CRCCHK_SSEG_ADDR: begin
                    rdata_q <= {{(16-SEG_W){1'b0}}, start_seg_q};
                end
                `CRCCHK_ESEG_ADDR: begin
                    rdata_q <= {{(16-SEG_W){1'b0}}, end_seg_q};
                end
                `CRCCHK_DATA_ADDR: begin
                    rdata_q <= {8'h00, input_byte_q};
                end
                `CRCCHK_RES_ADDR: begin
                    rdata_q <= result_q;
                end
                `CRCCHK_MOD_ADDR: begin
                    rdata_q <= {14'h0000, shift_order_select_q, auto_check_enable_q}; // see [R13]
                end
                `CRCCHK_STAT_ADDR: begin
                    rdata_q <= {15'h0000, irq_status};
                end
                `CRCCHK_MASK_ADDR: begin
                    rdata_q <= {15'h0000, irq_mask};
                end
                default: begin
                    rdata_q <= 16'h0000;
                end
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    // Memory request is a level for the whole fetch cycle run; the
    // word address always has bits 1:0 at zero
    assign mem_req   = (state_q == ST_FETCH); // see [R7] [R9]
    assign mem_addr  = {start_seg_q, start_addr_q, 2'b00}; // see [R10]

    assign reg_rdata    = rdata_q;
    assign auto_done    = done_q;
    assign halt_release = release_q;

endmodule // crcchk_top

// ===== verif/crcchk_top_properties.sv
// Concurrent checks on the ports of the checksum block top.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps

module crcchk_props #(
    parameter SEG_W = 8
) (
    input logic               clock,
    input logic               reset,
    input logic [15:0]        reg_addr,
    input logic [15:0]        reg_wdata,
    input logic               reg_wr,
    input logic               reg_rd,
    input logic [15:0]        reg_rdata,
    input logic               halt_active,
    input logic               safety_interrupt_enable,
    input logic               mem_req,
    input logic [SEG_W+15:0]  mem_addr,
    input logic [31:0]        mem_rdata,
    input logic               mem_valid,
    input logic               auto_done,
    input logic               halt_release,
    input logic               irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // A word is consumed when an answer meets an open fetch
    sequence word_taken_s;
        mem_req && mem_valid;
    endsequence
    // The following fetch, after the one-cycle gap
    sequence next_fetch_s;
        word_taken_s ##2 mem_req;
    endsequence

    // Fetch position, step and hold
    addr_aligned_a: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
        else $error("fetch address not word aligned");
    addr_step_a: assert property (next_fetch_s |-> mem_addr == $past(mem_addr, 2) + 24'h4)
        else $error("fetch address did not advance by one word");
    addr_hold_a: assert property (mem_req && !mem_valid |=> !mem_req || $stable(mem_addr))
        else $error("fetch address moved while waiting");
    word_gap_a: assert property (word_taken_s |=> !mem_req)
        else $error("no gap after a taken word");
    // Scan start and abort follow the halt level
    start_halt_a: assert property ($rose(mem_req) |-> $past(halt_active))
        else $error("fetch started outside halt");
    halt_abort_a: assert property (mem_req && !halt_active |=> !mem_req)
        else $error("fetch kept after halt ended");
    // Completion is a single pulse after the last word and stops the scan
    done_pulse_a: assert property (auto_done |-> $past(mem_req && mem_valid) ##1 !auto_done)
        else $error("completion pulse without a final word");
    done_stop_a: assert property (auto_done |-> !mem_req [*3])
        else $error("fetching went on after completion");
    release_pair_a: assert property ((auto_done || halt_release) |->
        halt_release == (auto_done && $past(safety_interrupt_enable)))
        else $error("halt release does not match completion and enable");
    irq_cause_a: assert property ($rose(irq) |-> auto_done || $past(reg_wr))
        else $error("interrupt rose without an event or register write");
endmodule // crcchk_props

bind crcchk_top crcchk_props #(.SEG_W(SEG_W)) u_props (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_active(halt_active),
    .safety_interrupt_enable(safety_interrupt_enable), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_valid(mem_valid), .auto_done(auto_done),
    .halt_release(halt_release), .irq(irq)
);

// ===== verif/crcchk_mem.sv
// Program memory read port model answering word fetches of the block.
// Assumes fetches are held until answered; latency set by the bench.
`timescale 1ns/100ps

module crcchk_mem (
    input  logic        clock,
    input  logic        reset,
    input  logic        mem_req,
    input  logic [23:0] mem_addr,
    input  logic [3:0]  lat,
    output logic [31:0] mem_rdata,
    output logic        mem_valid
);
    logic [3:0] wait_q;
    logic       valid_q;

    // Gated by the request, so a reply never lands after an abort
    assign mem_valid = valid_q && mem_req;

    // Wait lat cycles, then show one word; data churns when not answering
    always @(posedge clock) begin
        if (reset || !mem_req || valid_q) begin
            wait_q    <= 4'h0;
            valid_q   <= 1'b0;
            mem_rdata <= reset ? 32'ha5a50f0f : ~mem_rdata;
        end else if (wait_q == lat) begin
            valid_q   <= 1'b1;
            mem_rdata <= {mem_addr[15:0] ^ 16'h3c5a, mem_addr[23:8]};
        end else begin
            wait_q    <= wait_q + 4'h1;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule // crcchk_mem

// ===== verif/crcchk_tb.sv
// Self-checking bench: register map, manual bytes, memory scan, interrupt.
// Assumes the memory model on the fetch port and the bound checker.
`timescale 1ns/100ps
`include "crcchk_defs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end

module crcchk_tb;
    logic        clock, reset, reg_wr, reg_rd, halt_active, safety_interrupt_enable;
    logic [15:0] reg_addr, reg_wdata, reg_rdata;
    logic        mem_req, mem_valid, auto_done, halt_release, irq;
    logic [23:0] mem_addr;
    logic [31:0] mem_rdata;
    logic [3:0]  lat;
    int          n_mismatch = 0, cmp_count = 0, cyc = 0, n_taken = 0;
    logic [15:0] ra [10] = '{16'hf0d0, 16'hf0d2, 16'hf0d4, 16'hf0d6, 16'hf0d8,
                             16'hf0da, 16'hf0dc, 16'hf0de, 16'hf0e0, 16'hf0e2};
    logic [15:0] rv [10] = '{16'h0000, 16'hfffc, 16'h0000, 16'h000f, 16'h0000,
                             16'hffff, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

    crcchk_top #(.SEG_W(8)) uut (
        .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_active(halt_active),
        .safety_interrupt_enable(safety_interrupt_enable), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_valid(mem_valid),
        .auto_done(auto_done), .halt_release(halt_release), .irq(irq)
    );
    crcchk_mem u_mem (
        .clock(clock), .reset(reset), .mem_req(mem_req), .mem_addr(mem_addr),
        .lat(lat), .mem_rdata(mem_rdata), .mem_valid(mem_valid)
    );

    // One bit at a time, reflected or normal form of the generator
    function automatic logic [15:0] crc_byte(logic [15:0] c, logic [7:0] b, logic msb);
        logic fb;
        for (int i = 0; i < 8; i++) begin
            fb = msb ? c[15] ^ b[7-i] : c[0] ^ b[i];
            c = msb ? {c[14:0], 1'b0} : {1'b0, c[15:1]};
            if (fb)
                c = c ^ (msb ? `CRCCHK_POLY_MSB : `CRCCHK_POLY_LSB);
        end
        return c;
    endfunction
    // Word from the model's contents, lowest byte address first
    function automatic logic [15:0] crc_word(logic [15:0] c, logic [23:0] a, logic msb);
        logic [31:0] w;
        w = {a[15:0] ^ 16'h3c5a, a[23:8]};
        for (int k = 0; k < 4; k++)
            c = crc_byte(c, w[8*k +: 8], msb);
        return c;
    endfunction

    // Strobe stays up so writes can follow back to back; idle drops it
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
        @(posedge clock);
    endtask
    task automatic idle;
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rdchk(input logic [15:0] a, input logic [15:0] x);
        reg_addr <= a;
        reg_wr   <= 1'b0;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        `CHK(reg_rdata, x)
    endtask
    task automatic wrap_up;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // Hang guard, well above the fewer than two hundred cycles the run needs
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up;
        end
    end
    always @(posedge clock)
        if (mem_req && mem_valid)
            n_taken <= n_taken + 1;

    initial begin
        logic [15:0] e, seed, part;
        logic [7:0]  b, sg;
        logic        dir;
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        halt_active = 1'b0;
        safety_interrupt_enable = 1'b1;
        lat = 4'h0;
        void'($urandom(9658));
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        foreach (ra[i])
            rdchk(ra[i], rv[i]);
        // Manual mode, both orders, corner bytes first
        for (int d = 0; d < 2; d++) begin
            dir = d[0];
            seed = 16'($urandom);
            wr(16'hf0dc, {14'h0, dir, 1'b0});
            wr(16'hf0da, seed);
            e = seed;
            for (int i = 0; i < 8; i++) begin
                b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
                wr(16'hf0d8, {8'h00, b});
                e = crc_byte(e, b, dir);
                if (i[0])
                    rdchk(16'hf0da, e);
            end
            rdchk(16'hf0d8, {8'h00, b});
        end
        // Low address bits and an unmapped place
        wr(16'hf0d0, 16'h1237);
        wr(16'hf0d2, 16'h00ff);
        wr(16'hf0e2, 16'hbeef);
        rdchk(16'hf0d0, 16'h1234);
        rdchk(16'hf0d2, 16'h00fc);
        rdchk(16'hf0e2, 16'h0000);
        // Scan of four words that crosses into the next segment
        dir = 1'($urandom);
        sg = 8'($urandom) & 8'h7f;
        seed = 16'($urandom);
        lat <= 4'($urandom % 6);
        wr(16'hf0d4, {8'h00, sg});
        wr(16'hf0d0, 16'hfff8);
        wr(16'hf0d6, {8'h00, sg + 8'h01});
        wr(16'hf0d2, 16'h0007);
        wr(16'hf0e0, 16'h0001);
        wr(16'hf0da, seed);
        wr(16'hf0dc, {14'h0, dir, 1'b1});
        wr(16'hf0d0, 16'h1000);
        wr(16'hf0da, 16'h0000);
        wr(16'hf0d8, 16'h005a);
        rdchk(16'hf0d0, 16'hfff8);
        rdchk(16'hf0da, seed);
        e = seed;
        for (int w = 0; w < 4; w++) begin
            e = crc_word(e, {sg, 16'hfff8} + 24'(4 * w), dir);
            if (w == 1)
                part = e;
        end
        halt_active <= 1'b1;
        for (int k = 0; k < 300 && n_taken < 2; k++)
            @(posedge clock);
        halt_active <= 1'b0;
        repeat (3) @(posedge clock);
        `CHK(mem_req, 1'b0)
        rdchk(16'hf0d0, 16'h0000);
        rdchk(16'hf0d4, {8'h00, sg + 8'h01});
        rdchk(16'hf0da, part);
        halt_active <= 1'b1;
        for (int k = 0; k < 400 && auto_done !== 1'b1; k++)
            @(posedge clock);
        `CHK(halt_release, 1'b1)
        `CHK(irq, 1'b1)
        halt_active <= 1'b0;
        rdchk(16'hf0da, e);
        rdchk(16'hf0dc, {14'h0, dir, 1'b0});
        rdchk(16'hf0d0, 16'h0004);
        rdchk(16'hf0d2, 16'h0004);
        rdchk(16'hf0de, 16'h0001);
        // Mask, unmask, then clear by writing a one
        wr(16'hf0e0, 16'h0000);
        idle;
        `CHK(irq, 1'b0)
        wr(16'hf0e0, 16'h0001);
        idle;
        `CHK(irq, 1'b1)
        wr(16'hf0de, 16'h0001);
        idle;
        `CHK(irq, 1'b0)
        rdchk(16'hf0de, 16'h0000);
        // One-word scan with the halt release path disabled
        safety_interrupt_enable <= 1'b0;
        wr(16'hf0dc, {14'h0, dir, 1'b1});
        idle;
        halt_active <= 1'b1;
        for (int k = 0; k < 400 && auto_done !== 1'b1; k++)
            @(posedge clock);
        `CHK(auto_done, 1'b1)
        `CHK(halt_release, 1'b0)
        halt_active <= 1'b0;
        rdchk(16'hf0da, crc_word(e, {sg + 8'h01, 16'h0004}, dir));
        wrap_up;
    end
endmodule // crcchk_tb
